// ==== logic/fpg_defines.svh ====
`ifndef FPG_DEFINES_SVH
`define FPG_DEFINES_SVH
`define FPG_OFS_WDATA   8'h04
`define FPG_OFS_ECTRL   8'h08
`define FPG_OFS_KEY     8'h0C
`define FPG_OFS_SELF    8'h14
`define FPG_OFS_STAT    8'h18
`define FPG_OFS_IST     8'h20
`define FPG_OFS_IEN     8'h24
`define FPG_OFS_ICLR    8'h28
`define FPG_KEY_FIRST   8'hFA
`define FPG_KEY_SECOND  8'hF5
`define FPG_ERS_BLOCK   2'h1
`define FPG_ERS_SECTOR  2'h2
`define FPG_SELF_RST    1'h0
`define FPG_STAT_RST    4'h0
`define FPG_IRQ_RST     3'h0
`define FPG_RESP_OKAY   2'h0
`define FPG_RESP_SLVERR 2'h2
`endif

// ==== logic/fpg_pkg.sv ====
`default_nettype none
package fpg_pkg;
  // One-cycle command to the flash engine
  typedef struct packed {
    logic prog;
    logic blk_erase;
    logic sec_erase;
    logic data_area;
  } fpg_cmd_t;
  // Busy flags in status register order, bit 3 down to bit 0
  typedef struct packed {
    logic code_prog;
    logic code_erase;
    logic data_prog;
    logic data_erase;
  } fpg_busy_t;
  // Interrupt events, bit 2 down to bit 0
  typedef struct packed {
    logic key_error;
    logic refused;
    logic op_done;
  } fpg_evt_t;
  typedef enum logic [1:0] {
    FPG_KEY_IDLE,
    FPG_KEY_FIRST_SEEN,
    FPG_KEY_ARMED
  } fpg_key_state_t;
endpackage
`default_nettype wire

// ==== logic/fpg_unlock_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fpg_defines.svh"
module fpg_unlock_seq (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Key writes and consumption
  input  wire logic       key_wr,
  input  wire logic [7:0] key,
  input  wire logic       consume,
  // State
  output logic            armed_q,
  output logic            first_q,
  output logic            seq_err_q
);
  fpg_pkg::fpg_key_state_t state_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= fpg_pkg::FPG_KEY_IDLE;
    else if (consume)
      state_q <= fpg_pkg::FPG_KEY_IDLE;
    else if (key_wr)
    begin
      case (state_q)
        fpg_pkg::FPG_KEY_IDLE:
          if (key == `FPG_KEY_FIRST)
            state_q <= fpg_pkg::FPG_KEY_FIRST_SEEN;
        fpg_pkg::FPG_KEY_FIRST_SEEN:
          // A repeated first byte also spoils the pair
          if (key == `FPG_KEY_SECOND)
            state_q <= fpg_pkg::FPG_KEY_ARMED;
          else
            state_q <= fpg_pkg::FPG_KEY_IDLE;
        fpg_pkg::FPG_KEY_ARMED:
          state_q <= fpg_pkg::FPG_KEY_ARMED;
        default:
          state_q <= fpg_pkg::FPG_KEY_IDLE;
      endcase
    end
  end

  // Bus traffic other than key writes and a consuming start never touches the state, so the pair survives it
  assign armed_q = (state_q == fpg_pkg::FPG_KEY_ARMED);
  assign first_q = (state_q == fpg_pkg::FPG_KEY_FIRST_SEEN);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      seq_err_q <= 1'b0;
    else
      seq_err_q <= key_wr && first_q && (key != `FPG_KEY_SECOND) && !consume;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_pair_arms: assert property (
    (key_wr && first_q && key == `FPG_KEY_SECOND && !consume) |=> armed_q ##0 !first_q)
    else $error("second key after first did not arm");
  a_bad_drops: assert property (
    (key_wr && first_q && key != `FPG_KEY_SECOND) |=> !first_q && !armed_q && seq_err_q)
    else $error("wrong second key did not drop first key");
  a_pending_holds: assert property (
    (first_q && !key_wr && !consume) |=> first_q)
    else $error("pending first key lost without key write");
endmodule
`default_nettype wire

// ==== logic/fpg_guard.sv ====
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fpg_defines.svh"
module fpg_guard #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // System state
  input  wire logic              sys_low_speed,
  input  wire logic              target_data_area,
  // Flash engine
  output fpg_pkg::fpg_cmd_t      eng_cmd_q,
  output logic [31:0]            eng_wdata_q,
  input  wire logic              eng_done,
  // Processor and interrupt
  output logic                   cpu_stall_q,
  output logic                   irq_q
);
  logic                aw_full_q;
  logic                w_full_q;
  logic [ADDR_W-1:0]   aw_addr_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                wr_fire;
  logic [7:0]          wa;
  logic                wr_hit;
  logic                sel_wdata;
  logic                sel_ectrl;
  logic                sel_key;
  logic                sel_self;
  logic                sel_ien;
  logic                sel_iclr;
  logic [31:0]         rd_data;
  logic                rd_hit;
  logic                self_en_q;
  fpg_pkg::fpg_busy_t  busy_q;
  fpg_pkg::fpg_busy_t  busy_d;
  fpg_pkg::fpg_evt_t   ist_q;
  fpg_pkg::fpg_evt_t   ist_d;
  fpg_pkg::fpg_evt_t   ien_q;
  fpg_pkg::fpg_evt_t   evt;
  fpg_pkg::fpg_cmd_t   cmd_d;
  logic                key_armed;
  logic                key_first;
  logic                key_err;
  logic                prog_req;
  logic                ers_req;
  logic                go;
  logic [1:0]          ers_field;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: address and data taken in either order, one write at a time

  assign wr_fire = aw_full_q && w_full_q && !s_bvalid;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_full_q <= 1'b0;
      s_awready <= 1'b1;
      aw_addr_q <= '0;
    end
    else if (s_awvalid && s_awready)
    begin
      aw_full_q <= 1'b1;
      s_awready <= 1'b0;
      aw_addr_q <= s_awaddr;
    end
    else if (wr_fire)
    begin
      aw_full_q <= 1'b0;
      s_awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      w_full_q <= 1'b0;
      s_wready <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (s_wvalid && s_wready)
    begin
      w_full_q <= 1'b1;
      s_wready <= 1'b0;
      w_data_q <= s_wdata;
      w_strb_q <= s_wstrb;
    end
    else if (wr_fire)
    begin
      w_full_q <= 1'b0;
      s_wready <= 1'b1;
    end
  end

  assign wa        = 8'(aw_addr_q);
  assign wr_hit    = wa == `FPG_OFS_WDATA || wa == `FPG_OFS_ECTRL || wa == `FPG_OFS_KEY
                  || wa == `FPG_OFS_SELF || wa == `FPG_OFS_STAT || wa == `FPG_OFS_IST
                  || wa == `FPG_OFS_IEN || wa == `FPG_OFS_ICLR;
  assign sel_wdata = wr_fire && wa == `FPG_OFS_WDATA && |w_strb_q;
  assign sel_ectrl = wr_fire && wa == `FPG_OFS_ECTRL && w_strb_q[0];
  assign sel_key   = wr_fire && wa == `FPG_OFS_KEY && w_strb_q[0];
  assign sel_self  = wr_fire && wa == `FPG_OFS_SELF && w_strb_q[0];
  assign sel_ien   = wr_fire && wa == `FPG_OFS_IEN && w_strb_q[0];
  assign sel_iclr  = wr_fire && wa == `FPG_OFS_ICLR && w_strb_q[0];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_bvalid <= 1'b0;
      s_bresp  <= `FPG_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_bvalid <= 1'b1;
      s_bresp  <= wr_hit ? `FPG_RESP_OKAY : `FPG_RESP_SLVERR;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (8'(s_araddr))
      `FPG_OFS_WDATA: rd_data = eng_wdata_q;
      `FPG_OFS_ECTRL: rd_data = 32'h0000_0000;
      `FPG_OFS_KEY:   rd_data = 32'h0000_0000;
      `FPG_OFS_SELF:  rd_data = {31'h0000_0000, self_en_q};
      `FPG_OFS_STAT:  rd_data = {28'h000_0000, busy_q};
      `FPG_OFS_IST:   rd_data = {29'h0000_0000, ist_q};
      `FPG_OFS_IEN:   rd_data = {29'h0000_0000, ien_q};
      `FPG_OFS_ICLR:  rd_data = 32'h0000_0000;
      default:        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= `FPG_RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rdata   <= rd_data;
      s_rresp   <= rd_hit ? `FPG_RESP_OKAY : `FPG_RESP_SLVERR;
    end
    else if (s_rvalid && s_rready)
    begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key sequence

  fpg_unlock_seq u_seq (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .key_wr    (sel_key),
    .key       (w_data_q[7:0]),
    .consume   (go),
    .armed_q   (key_armed),
    .first_q   (key_first),
    .seq_err_q (key_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Enable bit and start requests

  // Only software clears the bit; completion leaves it alone
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      self_en_q <= `FPG_SELF_RST;
    else if (sel_self && !sys_low_speed)
      self_en_q <= w_data_q[0];
  end

  assign ers_field = w_data_q[1:0];
  assign prog_req  = sel_wdata;
  assign ers_req   = sel_ectrl && (ers_field == `FPG_ERS_BLOCK
                  || ers_field == `FPG_ERS_SECTOR);
  assign go        = (prog_req || ers_req) && self_en_q && key_armed;

  always_comb
  begin
    cmd_d           = '0;
    cmd_d.prog      = go && prog_req;
    cmd_d.blk_erase = go && ers_req && ers_field == `FPG_ERS_BLOCK;
    cmd_d.sec_erase = go && ers_req && ers_field == `FPG_ERS_SECTOR;
    cmd_d.data_area = go && target_data_area;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      eng_cmd_q <= '0;
    else
      eng_cmd_q <= cmd_d;
  end

  // Byte lanes honoured so a partial write keeps the other bytes
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      eng_wdata_q <= 32'h0000_0000;
    else if (sel_wdata)
      for (int i = 0; i < 4; i++)
        if (w_strb_q[i])
          eng_wdata_q[8*i +: 8] <= w_data_q[8*i +: 8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy flags and processor stall

  always_comb
  begin
    busy_d            = eng_done ? fpg_pkg::fpg_busy_t'(`FPG_STAT_RST) : busy_q;
    busy_d.code_prog  = busy_d.code_prog || (cmd_d.prog && !target_data_area);
    busy_d.code_erase = busy_d.code_erase || (ers_req && go && !target_data_area);
    busy_d.data_prog  = busy_d.data_prog || (cmd_d.prog && target_data_area);
    busy_d.data_erase = busy_d.data_erase || (ers_req && go && target_data_area);
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      busy_q <= `FPG_STAT_RST;
    else
      busy_q <= busy_d;
  end

  // Data-area work leaves the processor running
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cpu_stall_q <= 1'b0;
    else
      cpu_stall_q <= busy_d.code_prog || busy_d.code_erase;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set beats a clear in the same cycle

  // Packed order: key error, refused start, operation done
  assign evt           = {key_err, (prog_req || ers_req) && !go, eng_done && (|busy_q)};
  assign ist_d         = (ist_q & ~(sel_iclr ? w_data_q[2:0] : 3'h0)) | evt;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ist_q <= `FPG_IRQ_RST;
      ien_q <= `FPG_IRQ_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      ist_q <= ist_d;
      if (sel_ien)
        ien_q <= w_data_q[2:0];
      irq_q <= |(ist_d & (sel_ien ? w_data_q[2:0] : ien_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_start_needs_arm: assert property (
    (eng_cmd_q != '0) |-> $past(self_en_q) && $past(key_armed))
    else $error("engine started without enable and unlock");
  a_arm_consumed: assert property (
    (eng_cmd_q != '0) |-> !key_armed ##1 (!key_armed || $past(sel_key)))
    else $error("unlock not consumed by start");
  a_prog_start: assert property (
    (sel_wdata && self_en_q && key_armed) |=> eng_cmd_q.prog && !eng_cmd_q.blk_erase)
    else $error("data write did not start programming");
  a_erase_nofunc: assert property (
    (sel_ectrl && (ers_field == 2'h0 || ers_field == 2'h3)) |=> eng_cmd_q == '0)
    else $error("erase field 00 or 11 started an operation");
  a_self_lowspeed: assert property (
    (sel_self && sys_low_speed) |=> $stable(self_en_q))
    else $error("enable changed on low-speed clock");
  a_self_kept: assert property (
    (eng_done && !sel_self) |=> $stable(self_en_q))
    else $error("enable cleared by completion");
  a_code_stall: assert property (
    (eng_cmd_q.prog && !eng_cmd_q.data_area) |-> cpu_stall_q && busy_q.code_prog)
    else $error("code-area programming without stall");
  a_data_bgo: assert property (
    (eng_cmd_q != '0 && eng_cmd_q.data_area) |-> !cpu_stall_q
      && (busy_q.data_prog || busy_q.data_erase))
    else $error("data-area work stalled or not busy");
  a_resp_time: assert property (
    wr_fire |=> s_bvalid && s_awready && s_wready)
    else $error("write response late");

  c_prog: cover property (eng_cmd_q.prog);
  c_sector: cover property (eng_cmd_q.sec_erase && eng_cmd_q.data_area);
  c_refused: cover property (evt.refused ##[1:20] irq_q);
  c_done: cover property (busy_q.data_prog ##[1:50] eng_done);
endmodule
`default_nettype wire

// ==== bench/fpg_engine_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpg_engine_model #(
  parameter int DELAY = 20
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // Engine handshake
  input  wire fpg_pkg::fpg_cmd_t eng_cmd,
  output logic                   eng_done
);
  int cnt_q;
  // Fixed finishing time; the guard must not depend on it
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q    <= 0;
      eng_done <= 1'b0;
    end
    else
    begin
      eng_done <= (cnt_q == 1);
      if (eng_cmd != '0)
        cnt_q <= DELAY;
      else if (cnt_q > 0)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fpg_defines.svh"
module testbench;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} fpg_row_t;
  logic              mclk, arst_n, s_awvalid, s_awready, s_wvalid, s_wready;
  logic              s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic              sys_low_speed, target_data_area, eng_done, cpu_stall_q, irq_q;
  logic [7:0]        s_awaddr, s_araddr;
  logic [31:0]       s_wdata, s_rdata, eng_wdata_q, rd_d;
  logic [3:0]        s_wstrb;
  logic [3:0]        last_cmd = 4'h0;
  logic [1:0]        s_bresp, s_rresp, rd_r, wr_r;
  fpg_pkg::fpg_cmd_t eng_cmd_q;
  int                num_errors = 0;
  int                comparisons = 0;
  int                cmd_cnt = 0;
  fpg_row_t          rows [7] = '{'{8'h0C, 32'h0, 2'h0}, '{8'h14, 32'h0, 2'h0},
    '{8'h18, 32'h0, 2'h0}, '{8'h08, 32'h0, 2'h0}, '{8'h20, 32'h0, 2'h0},
    '{8'h24, 32'h0, 2'h0}, '{8'h30, 32'h0, 2'h2}};

  fpg_guard #(.ADDR_W(8)) u_dut (.mclk(mclk), .arst_n(arst_n),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .sys_low_speed(sys_low_speed), .target_data_area(target_data_area),
    .eng_cmd_q(eng_cmd_q), .eng_wdata_q(eng_wdata_q), .eng_done(eng_done),
    .cpu_stall_q(cpu_stall_q), .irq_q(irq_q));
  fpg_engine_model #(.DELAY(20)) u_engine (.mclk(mclk), .arst_n(arst_n),
    .eng_cmd(eng_cmd_q), .eng_done(eng_done));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Commands are one-cycle pulses, so latch them here rather than in the tasks
  always @(posedge mclk)
  begin
    if (eng_cmd_q !== 4'h0)
    begin
      last_cmd <= eng_cmd_q;
      cmd_cnt  <= cmd_cnt + 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    num_errors++;
    $display("MISMATCH %0t wait for %s ran out", $time, what);
    wrap_up();
  endtask

  task automatic end_test(input string what);
    $display("Test finished: %s", what);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Address and data go out together; bready and rready stay up between transfers
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_awready)
        s_awvalid <= 1'b0;
      if (s_wready)
        s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1 && n < 50);
    wr_r = s_bresp;
    if (n >= 50)
      hang("write response");
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_arready)
        s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1 && n < 50);
    rd_d = s_rdata;
    rd_r = s_rresp;
    if (n >= 50)
      hang("read data");
  endtask

  task automatic unlock;
    axi_wr(`FPG_OFS_KEY, {24'h0, `FPG_KEY_FIRST});
    axi_wr(`FPG_OFS_KEY, {24'h0, `FPG_KEY_SECOND});
  endtask

  task automatic exp_cmd(input int n, input logic [3:0] c);
    @(posedge mclk);
    chk(32'(cmd_cnt), 32'(n), "command count");
    chk({28'h0, last_cmd}, {28'h0, c}, "command code");
  endtask

  task automatic poll_idle;
    int n;
    n = 0;
    do
    begin
      axi_rd(`FPG_OFS_STAT);
      n++;
    end while (rd_d !== 32'h0 && n < 40);
    if (n >= 40)
      hang("busy clear");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    {sys_low_speed, target_data_area, s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    foreach (rows[i])
    begin
      axi_rd(rows[i].a);
      chk(rd_d, rows[i].d, "reset read");
      chk({30'h0, rd_r}, {30'h0, rows[i].r}, "read response");
    end
    end_test("reset values");
    axi_wr(8'h30, 32'h1);
    chk({30'h0, wr_r}, {30'h0, `FPG_RESP_SLVERR}, "unmapped write");
    axi_wr(`FPG_OFS_STAT, 32'hF);
    axi_rd(`FPG_OFS_STAT);
    chk(rd_d, 32'h0, "status written");
    sys_low_speed <= 1'b1;
    axi_wr(`FPG_OFS_SELF, 32'h1);
    axi_rd(`FPG_OFS_SELF);
    chk(rd_d, 32'h0, "enable on slow clock");
    sys_low_speed <= 1'b0;
    axi_wr(`FPG_OFS_SELF, 32'h1);
    axi_rd(`FPG_OFS_SELF);
    chk(rd_d, 32'h1, "enable set");
    axi_wr(`FPG_OFS_WDATA, 32'h55);
    exp_cmd(0, 4'h0);
    axi_wr(`FPG_OFS_ICLR, 32'h7);
    axi_wr(`FPG_OFS_IEN, 32'h1);
    end_test("enable gating");
    // Unrelated read between the key bytes, upper key bits set
    target_data_area <= 1'b1;
    axi_wr(`FPG_OFS_KEY, 32'h0000_00FA);
    axi_rd(`FPG_OFS_SELF);
    axi_wr(`FPG_OFS_KEY, 32'hFFFF_FFF5);
    axi_wr(`FPG_OFS_WDATA, 32'h1234_5678);
    exp_cmd(1, 4'b1001);
    chk(eng_wdata_q, 32'h1234_5678, "program data");
    axi_rd(`FPG_OFS_STAT);
    chk(rd_d, 32'h2, "data program busy");
    chk({31'h0, cpu_stall_q}, 32'h0, "no stall on data area");
    poll_idle();
    chk({31'h0, irq_q}, 32'h1, "done interrupt");
    axi_rd(`FPG_OFS_SELF);
    chk(rd_d, 32'h1, "enable kept");
    axi_wr(`FPG_OFS_ICLR, 32'h1);
    @(posedge mclk);
    chk({31'h0, irq_q}, 32'h0, "interrupt cleared");
    end_test("data program");
    axi_wr(`FPG_OFS_WDATA, 32'h1);
    exp_cmd(1, 4'b1001);
    axi_rd(`FPG_OFS_IST);
    chk(rd_d, 32'h2, "refused flag");
    chk({31'h0, irq_q}, 32'h0, "masked interrupt");
    axi_wr(`FPG_OFS_KEY, 32'hFA);
    axi_wr(`FPG_OFS_KEY, 32'h00);
    axi_wr(`FPG_OFS_KEY, 32'hF5);
    axi_wr(`FPG_OFS_ECTRL, 32'h1);
    exp_cmd(1, 4'b1001);
    axi_rd(`FPG_OFS_IST);
    chk(rd_d, 32'h6, "key error flag");
    axi_wr(`FPG_OFS_ICLR, 32'h7);
    end_test("refused starts");
    target_data_area <= 1'b0;
    unlock();
    axi_wr(`FPG_OFS_ECTRL, 32'h1);
    exp_cmd(2, 4'b0100);
    chk({31'h0, cpu_stall_q}, 32'h1, "stall on code area");
    axi_rd(`FPG_OFS_STAT);
    chk(rd_d, 32'h4, "code erase busy");
    poll_idle();
    chk({31'h0, cpu_stall_q}, 32'h0, "stall released");
    target_data_area <= 1'b1;
    unlock();
    axi_wr(`FPG_OFS_ECTRL, 32'h3);
    axi_wr(`FPG_OFS_ECTRL, 32'h0);
    exp_cmd(2, 4'b0100);
    axi_wr(`FPG_OFS_ECTRL, 32'h2);
    exp_cmd(3, 4'b0011);
    axi_rd(`FPG_OFS_STAT);
    chk(rd_d, 32'h1, "data erase busy");
    poll_idle();
    end_test("erase codes");
    // Code-area programming holds the processor until done
    target_data_area <= 1'b0;
    unlock();
    axi_wr(`FPG_OFS_WDATA, 32'h0000_00A5);
    exp_cmd(4, 4'b1000);
    chk({31'h0, cpu_stall_q}, 32'h1, "stall on code program");
    axi_rd(`FPG_OFS_STAT);
    chk(rd_d, 32'h8, "code program busy");
    poll_idle();
    chk({31'h0, cpu_stall_q}, 32'h0, "program stall released");
    end_test("code program");
    unlock();
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    axi_rd(`FPG_OFS_SELF);
    chk(rd_d, 32'h0, "enable after reset");
    axi_wr(`FPG_OFS_SELF, 32'h1);
    axi_wr(`FPG_OFS_WDATA, 32'h2);
    exp_cmd(4, 4'b1000);
    end_test("reset drops arm");
    wrap_up();
  end
endmodule
`default_nettype wire
